// *** src/tcbp_pkg.sv ***
// Purpose: Shared constants and carriers for the TDM channel byte processor
// Assumes: One channel byte per clock at most on each path
// Notes: Register offsets are word addresses on the 14-bit host port
package tcbp_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_STREAMS = 16;
  localparam int FIFO_DEPTH = 32;
  // ==========================================================
  // Register offsets (MODE_SEL_ADDR is a full address; others are block bases, low four bits select stream)
  localparam logic [13:0] MODE_SEL_ADDR = 14'h0001;
  localparam logic [9:0] CHK_CTRL_BASE = 10'h010;
  localparam logic [9:0] CHK_FIRST_BASE = 10'h011;
  localparam logic [9:0] CHK_COUNT_BASE = 10'h012;
  localparam logic [9:0] ERR_TALLY_BASE = 10'h013;
  localparam logic [9:0] QFORCE_BASE = 10'h014;
  // ==========================================================
  // Field positions
  localparam int CHK_GLOBAL_BIT = 5;
  localparam int GEN_GLOBAL_BIT = 4;
  localparam int TALLY_CLEAR_BIT = 1;
  localparam int STREAM_EN_BIT = 0;
  localparam int CONN_MODE_BIT = 0;
  localparam int VOICE_DATA_BIT = 4;
  localparam logic [1:0] FUNC_PATTERN = 2'h2;
  // ==========================================================
  // Reset values and tally saturation value
  localparam logic [14:0] PRBS_SEED = 15'h7fff;
  localparam logic [15:0] TALLY_MAX = 16'hffff;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [7:0] FIRST_RST = 8'h00;
  localparam logic [8:0] COUNT_RST = 9'h000;
  localparam logic [11:0] QFORCE_RST = 12'h000;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [3:0] stream;
    logic [7:0] data;
  } tcbp_out_word_t;
  typedef struct packed {
    logic [3:0] stream;
    logic [1:0] rate;
    logic [7:0] chan;
    logic [7:0] data;
  } tcbp_in_byte_t;
  typedef struct packed {
    logic voice_data;
    logic [1:0] in_law;
    logic [1:0] out_law;
  } tcbp_law_cfg_t;
endpackage

// *** src/tcbp_fifo.sv ***
// Purpose: Output byte buffer with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Input ready is registered from the next count, so it tracks each push
`timescale 1ns/1ps
module tcbp_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_valid = (cnt_r != '0);
  assign o_data = mem[rptr_r];
  always_comb begin
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wptr_r] <= i_data;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
      o_ready <= 1'b0;
    end else begin
      wptr_r <= wptr_r + AW'(push);
      rptr_r <= rptr_r + AW'(pop);
      cnt_r <= cnt_nxt;
      o_ready <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule // tcbp_fifo

// *** src/tcbp_law_xlate.sv ***
// Purpose: Per-channel coding-law translation of one byte
// Assumes: Laws differ only by inversion masks over sign/segment/step
// Notes: Voice A/mu conversion keeps segment and step, a small-area trade
`timescale 1ns/1ps
module tcbp_law_xlate
  import tcbp_pkg::*;
(
  input wire tcbp_law_cfg_t i_cfg,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data
);
  // ==========================================================
  // Inversion mask of one law
  function automatic logic [7:0] law_mask(input logic vd,
                                          input logic [1:0] law);
    logic [7:0] m;
    m = 8'h00;
    if (!vd) begin
      case (law)
        2'h0: m = 8'h55;
        2'h1: m = 8'h7f;
        default: m = 8'h00;
      endcase
    end else begin
      case (law)
        2'h0: m = 8'h00;
        2'h1: m = 8'h55;
        2'h2: m = 8'haa;
        default: m = 8'hff;
      endcase
    end
    return m;
  endfunction
  always_comb begin
    if (i_cfg.in_law == i_cfg.out_law) begin
      o_data = i_data;
    end else begin
      o_data = i_data ^ law_mask(i_cfg.voice_data, i_cfg.in_law) ^
               law_mask(i_cfg.voice_data, i_cfg.out_law);
    end
  end
endmodule // tcbp_law_xlate

// *** src/tcbp_core.sv ***
// Purpose: Pattern generators/checkers, law translation, quarter forcing
// Assumes: Host port writes take one cycle; reads answer next cycle
// Notes: Checker resynchronises itself from received bits
`timescale 1ns/1ps
module tcbp_core
  import tcbp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_reg_cs,
  input wire logic i_reg_wr,
  input wire logic [13:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_sw_valid,
  input wire logic [3:0] i_sw_stream,
  input wire logic [7:0] i_sw_data,
  input wire logic [15:0] i_sw_conn_low,
  input wire logic [4:0] i_sw_conn_high,
  output logic o_sw_ready,
  output logic o_out_valid,
  output tcbp_out_word_t o_out_word,
  input wire logic i_out_ready,
  input wire logic i_in_valid,
  input wire tcbp_in_byte_t i_in_byte,
  output logic o_in_valid,
  output tcbp_in_byte_t o_in_byte
);
  // ==========================================================
  // Helpers
  function automatic logic [22:0] prbs8(input logic [14:0] s,
                                        input logic [7:0] rx,
                                        input logic use_rx);
    logic [14:0] st;
    logic [7:0] b;
    logic e;
    st = s;
    b = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      e = st[14] ^ st[13];
      b[i] = e;
      st = {st[13:0], (use_rx ? rx[i] : e)};
    end
    return {st, b};
  endfunction
  function automatic logic [3:0] ones8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction
  // ==========================================================
  // Host registers
  logic chk_glob_r;
  logic gen_glob_r;
  logic [1:0] ctrl_r [NUM_STREAMS];
  logic [7:0] first_r [NUM_STREAMS];
  logic [8:0] count_r [NUM_STREAMS];
  logic [15:0] tally_r [NUM_STREAMS];
  logic [11:0] qforce_r [NUM_STREAMS];
  logic [9:0] a_blk;
  logic [3:0] a_st;
  logic wr_en;
  logic clr_pulse;
  assign a_blk = i_reg_addr[13:4];
  assign a_st = i_reg_addr[3:0];
  assign wr_en = i_reg_cs && i_reg_wr;
  assign clr_pulse = wr_en && (a_blk == CHK_CTRL_BASE) &&
                     i_reg_wdata[TALLY_CLEAR_BIT];
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      chk_glob_r <= 1'b0;
      gen_glob_r <= 1'b0;
    end else if (wr_en && i_reg_addr == MODE_SEL_ADDR) begin
      chk_glob_r <= i_reg_wdata[CHK_GLOBAL_BIT];
      gen_glob_r <= i_reg_wdata[GEN_GLOBAL_BIT];
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int s = 0; s < NUM_STREAMS; s++) begin
        ctrl_r[s] <= CTRL_RST;
        first_r[s] <= FIRST_RST;
        count_r[s] <= COUNT_RST;
        qforce_r[s] <= QFORCE_RST;
      end
    end else if (wr_en) begin
      case (a_blk)
        CHK_CTRL_BASE: ctrl_r[a_st] <= {1'b0, i_reg_wdata[STREAM_EN_BIT]};
        CHK_FIRST_BASE: first_r[a_st] <= i_reg_wdata[7:0];
        CHK_COUNT_BASE: count_r[a_st] <= i_reg_wdata[8:0];
        QFORCE_BASE: qforce_r[a_st] <= i_reg_wdata[11:0];
        default: ;
      endcase
    end
  end
  // Read answer one cycle after the select; unmapped reads are zero
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_cs && !i_reg_wr;
      o_reg_rdata <= 16'h0000;
      if (i_reg_cs && !i_reg_wr) begin
        if (i_reg_addr == MODE_SEL_ADDR) begin
          o_reg_rdata <= {10'h000, chk_glob_r, gen_glob_r, 4'h0};
        end else begin
          case (a_blk)
            CHK_CTRL_BASE: o_reg_rdata <= {14'h0000, ctrl_r[a_st]};
            CHK_FIRST_BASE: o_reg_rdata <= {8'h00, first_r[a_st]};
            CHK_COUNT_BASE: o_reg_rdata <= {7'h00, count_r[a_st]};
            ERR_TALLY_BASE: o_reg_rdata <= tally_r[a_st];
            QFORCE_BASE: o_reg_rdata <= {4'h0, qforce_r[a_st]};
            default: o_reg_rdata <= 16'h0000;
          endcase
        end
      end
    end
  end
  // ==========================================================
  // Output path: generator or law translation, then buffer
  logic [14:0] gen_st_r [NUM_STREAMS];
  logic [22:0] gen_step;
  logic pat_sel;
  logic push;
  logic [7:0] xl_data;
  tcbp_out_word_t push_word;
  tcbp_out_word_t fifo_word;
  logic fifo_valid;
  logic fifo_pop_rdy;
  assign pat_sel = gen_glob_r && i_sw_conn_low[CONN_MODE_BIT] &&
                   (i_sw_conn_low[2:1] == FUNC_PATTERN);
  assign push = i_sw_valid && o_sw_ready;
  assign gen_step = prbs8(gen_st_r[i_sw_stream], 8'h00, 1'b0);
  assign push_word = {i_sw_stream,
                      pat_sel ? gen_step[7:0] : xl_data};
  tcbp_law_xlate u_xlate (
    .i_cfg(tcbp_law_cfg_t'(i_sw_conn_high)),
    .i_data(i_sw_data),
    .o_data(xl_data)
  );
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int s = 0; s < NUM_STREAMS; s++) begin
        gen_st_r[s] <= PRBS_SEED;
      end
    end else if (push && pat_sel) begin
      gen_st_r[i_sw_stream] <= gen_step[22:8];
    end
  end
  // Back-pressure from the far side fills the buffer and drops ready
  tcbp_fifo #(
    .WIDTH($bits(tcbp_out_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_valid(i_sw_valid),
    .i_data(push_word),
    .o_ready(o_sw_ready),
    .o_valid(fifo_valid),
    .o_data(fifo_word),
    .i_ready(fifo_pop_rdy)
  );
  assign fifo_pop_rdy = !o_out_valid || i_out_ready;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_out_valid <= 1'b0;
      o_out_word <= '0;
    end else if (fifo_pop_rdy) begin
      o_out_valid <= fifo_valid;
      o_out_word <= fifo_word;
    end
  end
  // ==========================================================
  // Input path: quarter forcing
  logic [1:0] quarter;
  logic [2:0] qcode;
  logic [7:0] forced;
  always_comb begin
    case (i_in_byte.rate)
      2'h0: quarter = i_in_byte.chan[4:3];
      2'h1: quarter = i_in_byte.chan[5:4];
      2'h2: quarter = i_in_byte.chan[6:5];
      default: quarter = i_in_byte.chan[7:6];
    endcase
  end
  // Four-bit index: quarter 3 must reach bits 11..9 without wrapping
  assign qcode = qforce_r[i_in_byte.stream][{2'b00, quarter} +
                 {1'b0, quarter, 1'b0} +: 3];
  always_comb begin
    forced = i_in_byte.data;
    case (qcode)
      3'h4: forced[0] = 1'b0;
      3'h5: forced[0] = 1'b1;
      3'h6: forced[7] = 1'b0;
      3'h7: forced[7] = 1'b1;
      default: forced = i_in_byte.data;
    endcase
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_in_valid <= 1'b0;
      o_in_byte <= '0;
    end else begin
      o_in_valid <= i_in_valid;
      o_in_byte <= {i_in_byte.stream, i_in_byte.rate, i_in_byte.chan, forced};
    end
  end
  // ==========================================================
  // Input path: checkers
  logic [14:0] chk_st_r [NUM_STREAMS];
  logic [8:0] rem_r [NUM_STREAMS];
  logic [3:0] cs;
  logic chk_on;
  logic win_start;
  logic win_act;
  logic [22:0] chk_step;
  logic [3:0] nerr;
  logic [16:0] tally_sum;
  assign cs = i_in_byte.stream;
  assign chk_on = chk_glob_r && ctrl_r[cs][STREAM_EN_BIT];
  assign win_start = (rem_r[cs] == 9'h000) && (count_r[cs] != 9'h000) &&
                     (i_in_byte.chan == first_r[cs]);
  assign win_act = i_in_valid && chk_on && (win_start || rem_r[cs] != 0);
  assign chk_step = prbs8(chk_st_r[cs], forced, 1'b1);
  assign nerr = ones8(chk_step[7:0] ^ forced);
  assign tally_sum = {1'b0, tally_r[cs]} + {13'h0000, nerr};
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int s = 0; s < NUM_STREAMS; s++) begin
        chk_st_r[s] <= PRBS_SEED;
        rem_r[s] <= 9'h000;
      end
    end else if (i_in_valid) begin
      if (!chk_on) begin
        rem_r[cs] <= 9'h000;
      end else if (win_act) begin
        chk_st_r[cs] <= chk_step[22:8];
        rem_r[cs] <= win_start ? count_r[cs] - 9'h001
                               : rem_r[cs] - 9'h001;
      end
    end
  end
  // A clear that meets an error keeps the new errors
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int s = 0; s < NUM_STREAMS; s++) begin
        tally_r[s] <= 16'h0000;
      end
    end else begin
      if (clr_pulse) begin
        tally_r[a_st] <= 16'h0000;
      end
      if (win_act) begin
        if (clr_pulse && a_st == cs) begin
          tally_r[cs] <= {12'h000, nerr};
        end else if (tally_sum[16]) begin
          tally_r[cs] <= TALLY_MAX;
        end else begin
          tally_r[cs] <= tally_sum[15:0];
        end
      end
    end
  end
  // ==========================================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_mode_read;
    i_reg_cs && !i_reg_wr && i_reg_addr == MODE_SEL_ADDR;
  endsequence
  sequence s_mode_answer;
    ##1 o_reg_rvalid && o_reg_rdata[CHK_GLOBAL_BIT] == chk_glob_r &&
        o_reg_rdata[GEN_GLOBAL_BIT] == gen_glob_r;
  endsequence
  a_mode_read_back: assert property (s_mode_read |-> s_mode_answer)
    else $error("mode readback mismatch");
  a_reset_disables: assert property (disable iff (1'b0)
    i_sys_rst |=> !chk_glob_r && !gen_glob_r)
    else $error("enables not off after reset");
  a_tally_saturate: assert property (win_act && tally_r[cs] == TALLY_MAX &&
    !clr_pulse |=> tally_r[$past(cs)] == TALLY_MAX)
    else $error("tally wrapped");
  a_tally_counts: assert property (win_act && !clr_pulse && !tally_sum[16]
    |=> tally_r[$past(cs)] == $past(tally_r[cs]) + 16'($past(nerr)))
    else $error("tally step wrong");
  a_quarter_force: assert property (i_in_valid && qcode[2] |=>
    (o_in_byte.data[$past(qcode[1]) ? 7 : 0] == $past(qcode[0])))
    else $error("forced bit wrong");
  a_quarter_pass: assert property (i_in_valid && !qcode[2] |=>
    o_in_byte.data == $past(i_in_byte.data))
    else $error("normal quarter altered");
  a_law_same_pass: assert property (push && !pat_sel &&
    i_sw_conn_high[3:2] == i_sw_conn_high[1:0] |->
    push_word.data == i_sw_data)
    else $error("same law altered byte");
  a_gen_hold: assert property (push && !pat_sel |=>
    gen_st_r[$past(i_sw_stream)] == $past(gen_st_r[i_sw_stream]))
    else $error("generator moved off pattern channel");
  a_window_bound: assert property (win_act && win_start |=>
    rem_r[$past(cs)] == $past(count_r[cs]) - 9'h001)
    else $error("window length wrong");
  // Set wins: an error byte in the clear cycle keeps its own count
  sequence s_clear_alone;
    clr_pulse && !(win_act && a_st == cs);
  endsequence
  a_tally_clear: assert property (s_clear_alone |=>
    tally_r[$past(a_st)] == 16'h0000)
    else $error("tally not cleared");
  a_clear_set_wins: assert property (clr_pulse && win_act && a_st == cs |=>
    tally_r[$past(cs)] == 16'($past(nerr)))
    else $error("clear lost new errors");
  a_window_drop: assert property (i_in_valid && !chk_on |=>
    rem_r[$past(cs)] == 9'h000)
    else $error("disabled checker kept window");
  a_gen_advance: assert property (push && pat_sel |=>
    gen_st_r[$past(i_sw_stream)] != $past(gen_st_r[i_sw_stream]))
    else $error("generator did not step");
endmodule // tcbp_core

// *** test/tcbp_far_end.sv ***
// Purpose: Downstream sink for the output byte stream of the core
// Assumes: A word moves on valid and ready at a rising edge
// Notes: Stall holds ready low; slow drops ready every other cycle
`timescale 1ns/1ps
module tcbp_far_end
  import tcbp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_stall,
  input wire logic i_slow,
  input wire logic i_valid,
  input wire tcbp_out_word_t i_word,
  output logic o_ready
);
  // ==========================================================
  // Ready pacing and capture
  // Captured words wait here so the bench can compare in order
  tcbp_out_word_t got[$];
  logic tick_r;
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tick_r <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      tick_r <= ~tick_r;
      o_ready <= !i_stall && !(i_slow && tick_r);
      if (i_valid && o_ready) begin
        got.push_back(i_word);
      end
    end
  end
endmodule // tcbp_far_end

// *** test/tcbp_core_tb.sv ***
// Purpose: Self-checking bench for the channel byte processor
// Assumes: Host port one cycle per access, read data one cycle later
// Notes: Pattern checks rely on the self-synchronising receiver
`timescale 1ns/1ps
module tcbp_core_tb
  import tcbp_pkg::*;
;
  // ==========================================================
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs = 1'b0;
  logic wr = 1'b0;
  logic [13:0] addr = '0;
  logic [15:0] wdata = '0;
  logic [15:0] rdata;
  logic rvalid;
  logic sw_valid = 1'b0;
  logic [3:0] sw_stream = '0;
  logic [7:0] sw_data = '0;
  logic [15:0] conn_low = '0;
  logic [4:0] conn_high = '0;
  logic sw_ready;
  logic out_valid;
  tcbp_out_word_t out_word;
  logic out_ready;
  logic in_valid = 1'b0;
  tcbp_in_byte_t in_byte = '0;
  logic o_in_valid;
  tcbp_in_byte_t o_in_byte;
  logic stall = 1'b0;
  logic slow = 1'b0;
  int err_total = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  tcbp_core dut_u (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_cs(cs),
    .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_sw_valid(sw_valid),
    .i_sw_stream(sw_stream), .i_sw_data(sw_data),
    .i_sw_conn_low(conn_low), .i_sw_conn_high(conn_high),
    .o_sw_ready(sw_ready), .o_out_valid(out_valid),
    .o_out_word(out_word), .i_out_ready(out_ready),
    .i_in_valid(in_valid), .i_in_byte(in_byte),
    .o_in_valid(o_in_valid), .o_in_byte(o_in_byte));
  tcbp_far_end far_u (.i_core_clk(clk), .i_sys_rst(rst), .i_stall(stall),
    .i_slow(slow), .i_valid(out_valid), .i_word(out_word),
    .o_ready(out_ready));
  // ==========================================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic [13:0] ra(input logic [9:0] b, input int n);
    return {b, 4'(n)};
  endfunction
  function automatic logic [7:0] mask(input logic vd, input logic [1:0] l);
    if (vd) return {4{l}};
    return (l == 2'h0) ? 8'h55 : (l == 2'h1) ? 8'h7f : 8'h00;
  endfunction
  function automatic logic [7:0] forced(input logic [2:0] c,
                                        input logic [7:0] d);
    if (!c[2]) return d;
    if (!c[1]) return {d[7:1], c[0]};
    return {c[0], d[6:0]};
  endfunction
  task automatic reg_wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge clk);
    cs <= 1'b1;
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    cs <= 1'b0;
  endtask
  task automatic reg_rd(input logic [13:0] a, output logic [15:0] v);
    @(posedge clk);
    cs <= 1'b1;
    wr <= 1'b0;
    addr <= a;
    @(posedge clk);
    cs <= 1'b0;
    #1;
    v = (rvalid === 1'b1) ? rdata : 16'hxxxx;
  endtask
  task automatic sw_push(input logic [3:0] s, input logic [7:0] d,
                         input logic [15:0] cl, input logic [4:0] ch,
                         output bit ok, input int bound);
    int k;
    @(posedge clk);
    sw_valid <= 1'b1;
    sw_stream <= s;
    sw_data <= d;
    conn_low <= cl;
    conn_high <= ch;
    #1;
    k = 0;
    while (sw_ready !== 1'b1 && k < bound) begin
      @(posedge clk);
      #1;
      k++;
    end
    ok = (sw_ready === 1'b1);
    @(posedge clk);
    sw_valid <= 1'b0;
    sw_data <= ~d;
  endtask
  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (far_u.got.size() < n && k < 400) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic in_drive(input logic [3:0] s, input logic [1:0] r,
                          input logic [7:0] c, input logic [7:0] d);
    @(posedge clk);
    in_valid <= 1'b1;
    in_byte <= {s, r, c, d};
  endtask
  task automatic in_stop();
    @(posedge clk);
    in_valid <= 1'b0;
    in_byte.data <= ~in_byte.data;
  endtask
  task automatic frames(input int nf);
    for (int f = 0; f < nf; f++) begin
      for (int c = 0; c < 256; c++) in_drive(4'h7, 2'h3, 8'(c), 8'hff);
    end
    in_stop();
    repeat (2) @(posedge clk);
  endtask
  // ==========================================================
  // Watchdog, span well above the longest expected run
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  // ==========================================================
  // Tests
  initial begin
    logic [15:0] v;
    bit ok;
    int n;
    int qs;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] pat[12];
    logic [11:0] qv;
    logic [11:0] exp[$];
    logic [9:0] bs[4];
    logic [15:0] wv[4];
    logic [15:0] rv[4];
    bs = '{CHK_FIRST_BASE, CHK_COUNT_BASE, ERR_TALLY_BASE, QFORCE_BASE};
    wv = '{16'h00ab, 16'h01ff, 16'h1234, 16'h0fff};
    rv = '{16'h00ab, 16'h01ff, 16'h0000, 16'h0fff};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    reg_rd(MODE_SEL_ADDR, v);
    check(v, 16'h0000);
    reg_rd(ra(CHK_CTRL_BASE, 2), v);
    check(v, 16'h0000);
    reg_rd(14'h3fff, v);
    check(v, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      reg_rd(ra(bs[i], 2), v);
      check(v, 16'h0000);
      reg_wr(ra(bs[i], 2), wv[i]);
      reg_rd(ra(bs[i], 2), v);
      check(v, rv[i]);
    end
    // Generator off: pattern-marked channel carries fabric data
    sw_push(4'h3, 8'h3c, 16'h0005, 5'h00, ok, 40);
    wait_got(1);
    check(16'(far_u.got.pop_front()), 16'h33c);
    // Law translation through a stalled, then slow, far end
    stall <= 1'b1;
    for (int c = 0; c < 32; c++) begin
      d = 8'(c * 37 + 5);
      e = d;
      if (c[3:2] != c[1:0]) e = d ^ mask(c[4], c[3:2]) ^ mask(c[4], c[1:0]);
      sw_push(4'h1, d, 16'h0000, 5'(c), ok, 40);
      exp.push_back({4'h1, e});
    end
    n = 0;
    ok = 1'b1;
    while (ok && n < 8) begin
      sw_push(4'h1, 8'h00, 16'h0000, 5'h00, ok, 10);
      if (ok) exp.push_back(12'h100);
      n++;
    end
    check(16'(ok), 16'h0000);
    stall <= 1'b0;
    slow <= 1'b1;
    wait_got(exp.size());
    while (exp.size() > 0) begin
      check(16'(far_u.got.pop_front()), 16'(exp.pop_front()));
    end
    // Quarter forcing at both edges of every quarter, every rate
    for (int k = 0; k < 2; k++) begin
      qv = k ? 12'h6db : 12'hfac;
      reg_wr(ra(QFORCE_BASE, 5), {4'h0, qv});
      for (int r = 0; r < 4; r++) begin
        qs = 8 << r;
        for (int q = 0; q < 16; q++) begin
          d = q[0] ? 8'h81 : 8'h7e;
          e = forced(qv[3 * (q / 4) +: 3], d);
          in_drive(4'h5, 2'(r), 8'((q / 4) * qs + (q[0] ? qs - 1 : 0)), d);
          in_stop();
          #1;
          check(16'(o_in_valid), 16'h0001);
          check(16'(o_in_byte.data), 16'(e));
        end
      end
    end
    // Generated pattern looped back into a checker window
    reg_wr(MODE_SEL_ADDR, 16'h0030);
    reg_rd(MODE_SEL_ADDR, v);
    check(v, 16'h0030);
    for (int i = 0; i < 12; i++) begin
      sw_push(4'h3, 8'h00, 16'h0005, 5'h00, ok, 40);
    end
    wait_got(12);
    for (int i = 0; i < 12; i++) pat[i] = far_u.got[i].data;
    far_u.got.delete();
    reg_wr(ra(CHK_FIRST_BASE, 3), 16'h0010);
    reg_wr(ra(CHK_COUNT_BASE, 3), 16'h0004);
    repeat (50000) @(posedge clk);
    reg_wr(ra(CHK_CTRL_BASE, 3), 16'h0001);
    for (int w = 0; w < 3; w++) begin
      in_drive(4'h3, 2'h0, 8'h0e, 8'h00);
      for (int i = 0; i < 4; i++) begin
        d = (w == 2 && i == 0) ? 8'h80 : 8'h00;
        in_drive(4'h3, 2'h0, 8'(16 + i), pat[4 * w + i] ^ d);
      end
      in_drive(4'h3, 2'h0, 8'h14, 8'h00);
      in_stop();
      repeat (2) @(posedge clk);
      if (w == 0) begin
        reg_wr(ra(CHK_CTRL_BASE, 3), 16'h0003);
        reg_rd(ra(CHK_CTRL_BASE, 3), v);
        check(v, 16'h0001);
      end
      reg_rd(ra(ERR_TALLY_BASE, 3), v);
      check(v, (w == 2) ? 16'h0003 : 16'h0000);
    end
    // Saturation of the tally on a full-rate stream
    reg_wr(ra(CHK_FIRST_BASE, 7), 16'h0000);
    reg_wr(ra(CHK_COUNT_BASE, 7), 16'h0100);
    reg_wr(MODE_SEL_ADDR, 16'h0010);
    reg_wr(ra(CHK_CTRL_BASE, 7), 16'h0001);
    frames(1);
    reg_rd(ra(ERR_TALLY_BASE, 7), v);
    check(v, 16'h0000);
    reg_wr(MODE_SEL_ADDR, 16'h0030);
    frames(36);
    reg_rd(ra(ERR_TALLY_BASE, 7), v);
    check(v, TALLY_MAX);
    reg_wr(ra(CHK_CTRL_BASE, 7), 16'h0002);
    reg_rd(ra(ERR_TALLY_BASE, 7), v);
    check(v, 16'h0000);
    tally_and_finish();
  end
endmodule // tcbp_core_tb
